// >>> hw/dsk_drive_inputs.sv
// Drive select, side select and step input logic with register port
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "dsk_defs.svh"

module dsk_drive_inputs
  import dsk_pkg::*;
#(
  parameter logic       DOUBLE_SIDED = 1'b1,
  parameter logic [6:0] MAX_TRACK    = `DSK_MAX_TRK
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Wishbone slave
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  // Cable inputs, active low except direction
  input  wire logic [3:0]   drv_sel_n_i,
  input  wire logic         side_sel_n_i,
  input  wire logic         step_dir_i,
  input  wire logic         step_n_i,
  input  wire logic         wr_gate_n_i,
  input  wire logic         wr_data_n_i,
  // Drive side
  output logic              out_en_o,
  output logic              head_side_o,
  output logic              step_pulse_o,
  output logic              step_out_o,
  output logic              trk00_n_o
);

  // --------------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------------
  logic [`DSK_PIN_N-1:0] pins;
  logic [`DSK_PIN_N-1:0] pin_s;

  // All nine standard lines enter through the synchroniser
  assign pins = {wr_data_n_i, wr_gate_n_i, step_n_i, step_dir_i,
                 side_sel_n_i, drv_sel_n_i};

  dsk_sync u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (pins),
    .sync_o (pin_s)
  );

  // --------------------------------------------------------------------
  // Selection decode
  // --------------------------------------------------------------------
  dsk_state_t s_q;
  dsk_state_t s_d;
  logic       sel_w;
  logic       sel_side_w;

  dsk_sel_decode u_dec (
    .sel_n_i    (pin_s[`DSK_PIN_SEL]),
    .pos_i      (s_q.pos),
    .mode_i     (s_q.mode),
    .selected_o (sel_w),
    .side_o     (sel_side_w)
  );

  // --------------------------------------------------------------------
  // Step and bus decode terms
  // --------------------------------------------------------------------
  logic        step_s;
  logic        wg_s;
  logic        step_edge;
  logic        step_go;
  logic        outward;
  logic        access;
  logic [31:0] stat_w;

  assign step_s    = pin_s[`DSK_PIN_STEP];
  assign wg_s      = pin_s[`DSK_PIN_WG];
  // Step pulse is low-going; the move fires on its return high
  assign step_edge = step_s & ~s_q.step_prev;
  // Writing freezes the carriage; a deselected drive ignores steps
  assign step_go   = step_edge & wg_s & s_q.sel;
  // Direction level, optionally inverted for older controllers
  assign outward   = s_q.dir ^ s_q.dir_inv;
  assign access    = wb_cyc_i & wb_stb_i & ~s_q.ack;

  // Status word
  always_comb begin
    stat_w                 = 32'h0000_0000;
    stat_w[`DSK_STAT_SEL]  = s_q.sel;
    stat_w[`DSK_STAT_SIDE] = s_q.side;
    stat_w[`DSK_STAT_DIR]  = outward;
    stat_w[`DSK_STAT_WG]   = ~wg_s;
    stat_w[`DSK_STAT_BLK]  = s_q.blocked;
    stat_w[`DSK_STAT_TRK]  = s_q.track;
  end

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  always_comb begin
    s_d            = s_q;
    s_d.ack        = access;
    s_d.rdata      = 32'h0000_0000;
    s_d.step_prev  = step_s;
    s_d.wd_prev    = pin_s[`DSK_PIN_WD];
    s_d.step_pulse = 1'b0;
    s_d.sel        = sel_w;

    // Direction and side follow the cable only while selected
    if (s_q.sel) begin
      s_d.dir = pin_s[`DSK_PIN_DIR];
      if (!s_q.dbl) begin
        s_d.side = 1'b0;
      end else if (s_q.mode == DSK_SEL_SIDE) begin
        s_d.side = sel_side_w;
      end else begin
        s_d.side = ~pin_s[`DSK_PIN_SIDE];
      end
    end else if (!s_q.dbl) begin
      s_d.side = 1'b0;
    end

    // One track per accepted step, held at the end stops
    if (step_go) begin
      s_d.step_pulse = 1'b1;
      s_d.step_out   = outward;
      if (outward) begin
        if (s_q.track != 7'h00) begin
          s_d.track = s_q.track - 7'h01;
        end
      end else if (s_q.track < MAX_TRACK) begin
        s_d.track = s_q.track + 7'h01;
      end
    end

    // Flux transitions counted only under the write gate
    if (s_q.sel && !wg_s && s_q.wd_prev && !pin_s[`DSK_PIN_WD]) begin
      s_d.flux_cnt = s_q.flux_cnt + 16'h0001;
    end

    // Register access; read data lands with the ack
    if (access && wb_we_i) begin
      if (wb_adr_i == `DSK_OFS_CTRL) begin
        if (wb_sel_i[0]) begin
          s_d.pos     = wb_dat_i[`DSK_CTRL_POS];
          s_d.mode    = dsk_selmode_t'(wb_dat_i[`DSK_CTRL_MODE]);
          s_d.dir_inv = wb_dat_i[`DSK_CTRL_DINV];
          s_d.dbl     = wb_dat_i[`DSK_CTRL_DBL] & DOUBLE_SIDED;
        end
      end else if (wb_adr_i == `DSK_OFS_STAT) begin
        if (wb_sel_i[0] && wb_dat_i[`DSK_STAT_BLK]) begin
          s_d.blocked = 1'b0;
        end
      end else if (wb_adr_i == `DSK_OFS_FLUX) begin
        if (wb_sel_i[0] || wb_sel_i[1]) begin
          s_d.flux_cnt = 16'h0000;
        end
      end
    end else if (access) begin
      if (wb_adr_i == `DSK_OFS_CTRL) begin
        s_d.rdata[`DSK_CTRL_POS]  = s_q.pos;
        s_d.rdata[`DSK_CTRL_MODE] = s_q.mode;
        s_d.rdata[`DSK_CTRL_DINV] = s_q.dir_inv;
        s_d.rdata[`DSK_CTRL_DBL]  = s_q.dbl;
      end else if (wb_adr_i == `DSK_OFS_STAT) begin
        s_d.rdata = stat_w;
      end else if (wb_adr_i == `DSK_OFS_FLUX) begin
        s_d.rdata = {16'h0000, s_q.flux_cnt};
      end
    end

    // Step tried while writing: set wins over a same-cycle clear
    if (step_edge && s_q.sel && !wg_s) begin
      s_d.blocked = 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q            <= '0;
      s_q.pos        <= `DSK_POS_RST;
      s_q.mode       <= DSK_SEL_FOUR;
      s_q.dbl        <= DOUBLE_SIDED;
      s_q.step_prev  <= 1'b1;
      s_q.wd_prev    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign wb_dat_o     = s_q.rdata;
  assign wb_ack_o     = s_q.ack;
  // Shared cable outputs stay released unless this drive is selected
  assign out_en_o     = s_q.sel;
  assign head_side_o  = s_q.side;
  assign step_pulse_o = s_q.step_pulse;
  assign step_out_o   = s_q.step_out;
  assign trk00_n_o    = ~(s_q.sel && s_q.track == 7'h00);

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  sequence seq_trail;
    !step_s ##1 step_s;
  endsequence

  sequence seq_step_ok;
    seq_trail ##0 (wg_s && s_q.sel);
  endsequence

  a_step_outward: assert property (
    @(posedge clk_i) disable iff (rst_i)
    seq_step_ok ##0 (outward && s_q.track != 7'h00 && !s_q.step_prev)
    |=> s_q.track == $past(s_q.track) - 7'h01 && step_pulse_o && step_out_o)
    else $error("outward step did not move one track out");

  a_step_inward: assert property (
    @(posedge clk_i) disable iff (rst_i)
    seq_step_ok ##0 (!outward && s_q.track < MAX_TRACK && !s_q.step_prev)
    |=> s_q.track == $past(s_q.track) + 7'h01 && !step_out_o)
    else $error("inward step did not move one track in");

  a_dir_invert: assert property (
    @(posedge clk_i) disable iff (rst_i)
    step_go |=> step_out_o == ($past(s_q.dir) ^ $past(s_q.dir_inv)))
    else $error("direction option not applied");

  a_write_freeze: assert property (
    @(posedge clk_i) disable iff (rst_i)
    step_edge && s_q.sel && !wg_s |=> $stable(s_q.track) && !step_pulse_o && s_q.blocked)
    else $error("step moved head under write gate");

  a_desel_ignore: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !s_q.sel |=> $stable(s_q.track) && $stable(s_q.dir) && !step_pulse_o)
    else $error("deselected drive reacted to cable");

  a_out_enable: assert property (
    @(posedge clk_i) disable iff (rst_i)
    sel_w |=> out_en_o ##0 (trk00_n_o == (s_q.track != 7'h00)))
    else $error("output enable not following selection");

  a_single_side: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !s_q.dbl && !$past(s_q.dbl) |-> !head_side_o)
    else $error("single-sided drive picked side one");

  a_side_level: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_q.sel && s_q.dbl && s_q.mode == DSK_SEL_FOUR
    |=> head_side_o == !$past(pin_s[`DSK_PIN_SIDE]))
    else $error("side input level not honoured");

  // Odd line of the own pair low means side one
  a_pair_side: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_q.sel && s_q.dbl && s_q.mode == DSK_SEL_SIDE
    |=> head_side_o == !$past(pin_s[{s_q.pos[1], 1'b1}]))
    else $error("select pair did not choose the side");

  a_eight_decode: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_q.mode == DSK_SEL_EIGHT && !pin_s[0] && ~pin_s[3:1] == s_q.pos
    |=> s_q.sel)
    else $error("eight-drive code not decoded");

  a_reset_pos: assert property (
    @(posedge clk_i)
    rst_i |=> s_q.pos == `DSK_POS_RST && s_q.mode == DSK_SEL_FOUR)
    else $error("position not drive one after reset");

  a_own_line: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_q.mode == DSK_SEL_FOUR |-> sel_w == !pin_s[s_q.pos[1:0]])
    else $error("selection not on own line");

  a_ack_single: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule

// >>> hw/dsk_sel_decode.sv
// Decode of the select lines into drive selection and head side
`timescale 1ns/1ps
`include "dsk_defs.svh"

module dsk_sel_decode
  import dsk_pkg::*;
(
  input  wire logic [3:0]   sel_n_i,
  input  wire logic [2:0]   pos_i,
  input  dsk_selmode_t      mode_i,
  output logic              selected_o,
  output logic              side_o
);

  // One-hot position of a 3-bit drive number
  function automatic logic [7:0] one_hot8(input logic [2:0] n);
    one_hot8 = 8'h01 << n;
  endfunction

  logic [2:0] code;
  logic [1:0] pair;

  // Lines 2..4 weigh 1, 2, 4 when asserted (low)
  assign code = ~sel_n_i[3:1];
  assign pair = {pos_i[1], 1'b0};

  // Selection decode per mode
  always_comb begin
    selected_o = 1'b0;
    side_o     = 1'b0;
    case (mode_i)
      DSK_SEL_EIGHT: begin
        // Line 1 is the common enable
        selected_o = ~sel_n_i[0] &
                     (|(one_hot8(code) & one_hot8(pos_i)));
      end
      DSK_SEL_SIDE: begin
        // A line pair per drive; odd line picks side one
        selected_o = ~sel_n_i[pair] | ~sel_n_i[pair + 2'h1];
        side_o     = ~sel_n_i[pair + 2'h1];
      end
      default: begin
        // Only the one line of this position answers
        selected_o = ~sel_n_i[pos_i[1:0]];
      end
    endcase
  end

endmodule

// >>> hw/dsk_sync.sv
// Two-stage synchroniser for the drive input pins
`timescale 1ns/1ps
`include "dsk_defs.svh"

module dsk_sync
  import dsk_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic [`DSK_PIN_N-1:0]  pin_i,
  output logic      [`DSK_PIN_N-1:0]  sync_o
);

  dsk_sync_state_t s_q;
  dsk_sync_state_t s_d;

  // Idle cable level is high on every line, so reset to all ones
  always_comb begin
    s_d      = s_q;
    s_d.meta = pin_i;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '{meta: 9'h1ff, sync: 9'h1ff};
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_o = s_q.sync;

  // Output is the pin two edges late
  a_sync_delay: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i, 2) |-> sync_o == $past(pin_i, 2))
    else $error("sync output not two cycles behind pin");

endmodule

// >>> shared/dsk_defs.svh
// Offsets, field positions, reset values and counts of the drive input block
`ifndef DSK_DEFS_SVH
`define DSK_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define DSK_OFS_CTRL   8'h00
`define DSK_OFS_STAT   8'h04
`define DSK_OFS_FLUX   8'h08

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define DSK_CTRL_POS   2:0
`define DSK_CTRL_MODE  5:4
`define DSK_CTRL_DINV  6
`define DSK_CTRL_DBL   7

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define DSK_STAT_SEL   0
`define DSK_STAT_SIDE  1
`define DSK_STAT_DIR   2
`define DSK_STAT_WG    3
`define DSK_STAT_BLK   4
`define DSK_STAT_TRK   14:8

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define DSK_POS_RST    3'h0
`define DSK_TRK_W      7
`define DSK_MAX_TRK    7'h4c
`define DSK_PIN_N      9

// Pin positions inside the synchronised input vector
`define DSK_PIN_SEL    3:0
`define DSK_PIN_SIDE   4
`define DSK_PIN_DIR    5
`define DSK_PIN_STEP   6
`define DSK_PIN_WG     7
`define DSK_PIN_WD     8

`endif

// >>> shared/dsk_pkg.sv
// Types shared by the drive input block
package dsk_pkg;

  // Selection modes
  typedef enum logic [1:0] {
    DSK_SEL_FOUR  = 2'b00,
    DSK_SEL_EIGHT = 2'b01,
    DSK_SEL_SIDE  = 2'b10
  } dsk_selmode_t;

  // Synchroniser state: first and second stage
  typedef struct packed {
    logic [8:0] meta;
    logic [8:0] sync;
  } dsk_sync_state_t;

  // Main block state
  typedef struct packed {
    logic         ack;
    logic [31:0]  rdata;
    logic [2:0]   pos;
    dsk_selmode_t mode;
    logic         dir_inv;
    logic         dbl;
    logic [6:0]   track;
    logic         sel;
    logic         dir;
    logic         side;
    logic         step_prev;
    logic         wd_prev;
    logic         step_pulse;
    logic         step_out;
    logic         blocked;
    logic [15:0]  flux_cnt;
  } dsk_state_t;

endpackage

// >>> sim/dsk_host_model.sv
// Host controller model that drives the drive's cable inputs
`timescale 1ns/1ps

module dsk_host_model (
  input  wire logic       clk_i,
  output logic      [3:0] sel_n_o,
  output logic            side_n_o,
  output logic            dir_o,
  output logic            step_n_o,
  output logic            wg_n_o,
  output logic            wd_n_o
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  // Terminated lines float high, so idle is logical one everywhere
  initial begin
    sel_n_o  = 4'hf;
    side_n_o = 1'b1;
    dir_o    = 1'b1;
    step_n_o = 1'b1;
    wg_n_o   = 1'b1;
    wd_n_o   = 1'b1;
  end

  // ----------------------------------------------------------------
  // Line levels
  // ----------------------------------------------------------------
  // Select by pulling one line low, or a binary code plus enable
  task automatic lines(input logic [3:0] s, input logic sd, input logic d,
                       input logic wg);
    @(posedge clk_i);
    sel_n_o  <= s;
    side_n_o <= sd;
    dir_o    <= d;
    wg_n_o   <= wg;
    // Generous settle beyond the synchroniser depth
    repeat (8) @(posedge clk_i);
  endtask

  // Step pulses, each phase longer than the three cycle minimum
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_i);
      step_n_o <= 1'b0;
      wd_n_o   <= 1'b0;
      repeat (4) @(posedge clk_i);
      step_n_o <= 1'b1;
      wd_n_o   <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
    repeat (6) @(posedge clk_i);
  endtask
endmodule

// >>> sim/test_dsk_drive_inputs.sv
// Self-checking bench for the drive select and step input block
`timescale 1ns/1ps

module test_dsk_drive_inputs;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic [3:0]  sel_n;
  logic        side_n, dir, step_n, wg_n, wd_n;
  logic        out_en, head, spulse, sout, trk00_n;
  logic [31:0] q;
  int          failures = 0;
  int          n_checks = 0;
  int          pulses   = 0;
  int          cycles   = 0;

  // Clock at 250 MHz
  always #2 clk_i = ~clk_i;

  dsk_host_model i_host (
    .clk_i(clk_i), .sel_n_o(sel_n), .side_n_o(side_n), .dir_o(dir),
    .step_n_o(step_n), .wg_n_o(wg_n), .wd_n_o(wd_n)
  );

  dsk_drive_inputs i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .drv_sel_n_i(sel_n),
    .side_sel_n_i(side_n), .step_dir_i(dir), .step_n_i(step_n),
    .wr_gate_n_i(wg_n), .wr_data_n_i(wd_n), .out_en_o(out_en),
    .head_side_o(head), .step_pulse_o(spulse), .step_out_o(sout),
    .trk00_n_o(trk00_n)
  );

  // Count track moves seen at the port; a missed pulse shows here
  always @(posedge clk_i) begin
    if (spulse === 1'b1) pulses <= pulses + 1;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic cycle: request held until ack is sampled, then released
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hf;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (n >= 100) failures++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0); chk(q, 32'h80);
    i_host.lines(4'hf, 1'b1, 1'b0, 1'b1); chk(32'(out_en), 32'h0);
    i_host.lines(4'he, 1'b1, 1'b0, 1'b1); chk(32'(out_en), 32'h1);
    chk(32'(trk00_n), 32'h0);
    i_host.lines(4'hd, 1'b1, 1'b0, 1'b1); chk(32'(out_en), 32'h0);
    // Side input, then the single-sided setting ignoring it
    i_host.lines(4'he, 1'b0, 1'b0, 1'b1); chk(32'(head), 32'h1);
    i_host.lines(4'he, 1'b1, 1'b0, 1'b1); chk(32'(head), 32'h0);
    wb(1'b1, 8'h00, 32'h00);
    i_host.lines(4'he, 1'b0, 1'b0, 1'b1); chk(32'(head), 32'h0);
    wb(1'b1, 8'h00, 32'h80);
    // Inward steps raise the track, one per pulse
    i_host.pulse(3); chk(32'(pulses), 32'd3);
    wb(1'b0, 8'h04, 32'h0); chk(q, 32'h0000_0303);
    chk(32'(sout), 32'h0);
    i_host.lines(4'he, 1'b0, 1'b1, 1'b1); i_host.pulse(1);
    wb(1'b0, 8'h04, 32'h0); chk(32'(q[14:8]), 32'h2);
    chk(32'(sout), 32'h1);
    // Inverted meaning: a high direction now moves inward
    wb(1'b1, 8'h00, 32'hc0); i_host.pulse(1);
    wb(1'b0, 8'h04, 32'h0); chk(32'(q[14:8]), 32'h3);
    wb(1'b1, 8'h00, 32'h80);
    // Steps during a write are blocked and flagged
    i_host.lines(4'he, 1'b0, 1'b0, 1'b0); i_host.pulse(2);
    wb(1'b0, 8'h04, 32'h0); chk(q, 32'h0000_031b);
    chk(32'(q[4]), 32'h1);
    // Two write-data edges fell under the gate; any write to byte lane 0 or 1 clears the count
    wb(1'b0, 8'h08, 32'h0); chk(q, 32'h2);
    wb(1'b1, 8'h08, 32'h0); wb(1'b0, 8'h08, 32'h0); chk(q, 32'h0);
    // Deselected drive ignores steps on a shared cable
    i_host.lines(4'hf, 1'b0, 1'b0, 1'b1); i_host.pulse(2);
    wb(1'b0, 8'h04, 32'h0); chk(32'(q[14:8]), 32'h3);
    chk(32'(pulses), 32'd5);
    // Blocked flag clears on a written one
    wb(1'b1, 8'h04, 32'h10); wb(1'b0, 8'h04, 32'h0); chk(32'(q[4]), 32'h0);
    // Eight-drive decode at position five, every code with enable
    wb(1'b1, 8'h00, 32'h95);
    for (int c = 0; c < 8; c++) begin
      i_host.lines({~c[2], ~c[1], ~c[0], 1'b0}, 1'b1, 1'b0, 1'b1);
      chk(32'(out_en), (c == 5) ? 32'h1 : 32'h0);
    end
    i_host.lines(4'b0101, 1'b1, 1'b0, 1'b1); chk(32'(out_en), 32'h0);
    // Select lines pick the side; the side input is overridden
    wb(1'b1, 8'h00, 32'ha0);
    i_host.lines(4'hd, 1'b0, 1'b0, 1'b1); chk(32'(head), 32'h1);
    chk(32'(out_en), 32'h1);
    i_host.lines(4'he, 1'b0, 1'b0, 1'b1); chk(32'(head), 32'h0);
    // Unmapped place reads zero and swallows writes
    wb(1'b1, 8'h40, 32'h5); wb(1'b0, 8'h40, 32'h0); chk(q, 32'h0);
    wb(1'b0, 8'h00, 32'h0); chk(q, 32'ha0);
    // Mid-run reset brings back drive one; a changed position then answers
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0); chk(q, 32'h80);
    wb(1'b1, 8'h00, 32'h81);
    i_host.lines(4'hd, 1'b1, 1'b0, 1'b1); chk(32'(out_en), 32'h1);
    // Unused mode code behaves as four-drive selection
    wb(1'b1, 8'h00, 32'hb1);
    i_host.lines(4'hd, 1'b1, 1'b0, 1'b1); chk(32'(out_en), 32'h1);
    conclude();
  end
endmodule
